// ---- logic/tsp_protect_ctrl.sv ----
// Control and status logic of the source-port protection companion
`timescale 1ns/1ps
module tsp_protect_ctrl
    import tsp_pkg::*;
#(
    parameter int OCP_HOLD = OCP_HOLD_CYCLES,
    parameter logic PART_CODE = 1'b0 // Arbitrary neutral value
)
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic en_i,
    input wire logic addr_sel_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic ovp_cc_i,
    input wire logic otp_i,
    input wire logic ocp_bus_i,
    input wire logic ocp_cable_i,
    output logic load_switch_gate_en_o,
    output logic cable_power_route_a_o,
    output logic cable_power_route_b_o,
    output logic bus_power_discharge_en_o,
    output logic cable_power_discharge_en_o,
    output logic [1:0] cc_path_mode_o,
    output logic cc_ovp_en_o,
    output logic current_sense_out_en_o,
    output logic bus_ocp_en_o,
    output logic fault_out_n_o,
    output logic fault_out_n_oe_o
);
    typedef struct packed {
        logic [PIN_COUNT-1:0] ff1;
        logic [PIN_COUNT-1:0] ff2;
        logic [PIN_COUNT-1:0] ff3;
        logic [PIN_COUNT-1:0] pin;
        logic addr_lsb;
        logic [7:0] ctrl;
        logic ocp_bus;
        logic ocp_cable;
        logic [HOLD_W-1:0] hold;
        logic gate;
        logic route_a;
        logic route_b;
        logic dis_bus;
        logic dis_cable;
        logic [1:0] cc_mode;
        logic ovp_en;
        logic sense_en;
        logic ocp_en;
        logic fault;
    } tsp_ctrl_t;

    tsp_ctrl_t cur_reg;
    tsp_ctrl_t cur_next;
    logic [PIN_COUNT-1:0] pins_raw;
    logic [PIN_COUNT-1:0] pin_next;
    logic func_rst;
    logic wr_stb;
    logic [7:0] wr_ptr;
    logic [7:0] wr_data;
    logic [7:0] rd_ptr;
    logic [7:0] rd_data;
    logic [7:0] ack_byte;
    logic [7:0] flag_byte;
    logic [1:0] mode;
    logic normal;
    logic low_power;
    logic tripped;
    logic hot;
    logic ctrl_write;
    logic recovery;
    logic route_a_on;
    logic route_b_on;

    assign pins_raw[PIN_EN] = en_i;
    assign pins_raw[PIN_ADDR_SEL] = addr_sel_i;
    assign pins_raw[PIN_OVP_CC] = ovp_cc_i;
    assign pins_raw[PIN_OTP] = otp_i;
    assign pins_raw[PIN_OCP_BUS] = ocp_bus_i;
    assign pins_raw[PIN_OCP_CABLE] = ocp_cable_i;

    // Three-stage pin synchronisers; change taken when last two agree
    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi = gi + 1) begin : g_pin_sync
            assign pin_next[gi] = (cur_reg.ff2[gi] == cur_reg.ff3[gi]) ? cur_reg.ff3[gi] : cur_reg.pin[gi];
        end
    endgenerate

    // Enable pin doubles as the functional reset
    assign func_rst = rst_i || !cur_reg.pin[PIN_EN];

    tsp_i2c_target u_i2c (
        .clk_sys_i(clk_sys_i),
        .rst_i(func_rst),
        .addr_lsb_i(cur_reg.addr_lsb),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .sda_o(sda_o),
        .sda_oe_o(sda_oe_o),
        .wr_stb_o(wr_stb),
        .wr_ptr_o(wr_ptr),
        .wr_data_o(wr_data),
        .rd_ptr_o(rd_ptr),
        .rd_data_i(rd_data)
    );

    // Unused code 11 behaves as hibernate
    assign mode = (cur_reg.ctrl[BIT_MODE_HI:BIT_MODE_LO] == MODE_UNUSED) ? MODE_HIBERNATE
                  : cur_reg.ctrl[BIT_MODE_HI:BIT_MODE_LO];
    assign normal = (mode == MODE_NORMAL);
    assign low_power = (mode == MODE_LOW_POWER);
    assign tripped = cur_reg.ocp_bus || cur_reg.ocp_cable;
    assign hot = cur_reg.pin[PIN_OTP];
    assign ctrl_write = wr_stb && (wr_ptr == REG_CONTROL_WRITE);
    // Recovery only once the hold time has run out
    assign recovery = ctrl_write && ((wr_data & RECOVERY_MASK) == RECOVERY_VALUE)
                      && (cur_reg.hold == '0);

    assign route_a_on = normal && !tripped && !hot
                        && (cur_reg.ctrl[BIT_ROUTE_B:BIT_ROUTE_A] == ROUTE_A);
    assign route_b_on = normal && !tripped && !hot
                        && (cur_reg.ctrl[BIT_ROUTE_B:BIT_ROUTE_A] == ROUTE_B);

    // Acknowledge shows what is applied, not what was written, except bit 3, which echoes the written bit
    assign ack_byte = {cur_reg.dis_cable, cur_reg.dis_bus, mode, cur_reg.ctrl[BIT_ACK3],
                       cur_reg.gate, cur_reg.route_b, cur_reg.route_a};
    assign flag_byte = {PART_CODE, 1'b0, cur_reg.ocp_bus, normal && cur_reg.pin[PIN_OVP_CC],
                        hot, 1'b0, cur_reg.ocp_bus, cur_reg.ocp_cable};

    always_comb begin
        unique case (rd_ptr)
            REG_CONTROL_ACK: rd_data = ack_byte;
            REG_FAULT_FLAGS: rd_data = flag_byte;
            default: rd_data = IDLE_BYTE;
        endcase
    end

    always_comb begin
        cur_next = cur_reg;
        cur_next.ff1 = pins_raw;
        cur_next.ff2 = cur_reg.ff1;
        cur_next.ff3 = cur_reg.ff2;
        cur_next.pin = pin_next;
        if (func_rst) begin
            // Strap caught while held in reset, stable by release
            cur_next.addr_lsb = cur_reg.pin[PIN_ADDR_SEL];
            cur_next.ctrl = CONTROL_RESET;
            cur_next.ocp_bus = 1'b0;
            cur_next.ocp_cable = 1'b0;
            cur_next.hold = '0;
            cur_next.gate = 1'b0;
            cur_next.route_a = 1'b0;
            cur_next.route_b = 1'b0;
            cur_next.dis_bus = 1'b0;
            cur_next.dis_cable = 1'b0;
            cur_next.cc_mode = CC_OFF;
            cur_next.ovp_en = 1'b0;
            cur_next.sense_en = 1'b0;
            cur_next.ocp_en = 1'b0;
            cur_next.fault = 1'b0;
        end else begin
            if (ctrl_write) begin
                cur_next.ctrl = wr_data;
            end
            if (cur_reg.hold != '0) begin
                cur_next.hold = cur_reg.hold - HOLD_W'(1);
            end
            if (recovery) begin
                cur_next.ocp_bus = 1'b0;
                cur_next.ocp_cable = 1'b0;
            end
            // New trip wins over a recovery in the same cycle
            if (normal && cur_reg.pin[PIN_OCP_BUS]) begin
                cur_next.ocp_bus = 1'b1;
                cur_next.hold = HOLD_W'(OCP_HOLD);
            end
            if (normal && cur_reg.pin[PIN_OCP_CABLE]) begin
                cur_next.ocp_cable = 1'b1;
                cur_next.hold = HOLD_W'(OCP_HOLD);
            end
            cur_next.gate = normal && !tripped && !hot && cur_reg.ctrl[BIT_GATE];
            cur_next.route_a = route_a_on;
            cur_next.route_b = route_b_on;
            cur_next.dis_bus = normal && (cur_reg.ctrl[BIT_BUS_DIS] || tripped);
            // Never discharge into a closed cable power switch
            cur_next.dis_cable = normal && (cur_reg.ctrl[BIT_CABLE_DIS] || tripped)
                                 && !route_a_on && !route_b_on
                                 && !cur_reg.route_a && !cur_reg.route_b;
            if (normal) begin
                cur_next.cc_mode = (cur_reg.hold != '0 || hot) ? CC_OFF : CC_FULL;
            end else if (low_power) begin
                cur_next.cc_mode = CC_HIGH_OHMIC;
            end else begin
                cur_next.cc_mode = CC_OFF;
            end
            cur_next.ovp_en = (normal && !hot) || low_power;
            cur_next.sense_en = normal;
            cur_next.ocp_en = normal && !tripped;
            cur_next.fault = normal && (cur_reg.pin[PIN_OVP_CC] || hot || tripped);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            cur_reg <= '0;
        end else begin
            cur_reg <= cur_next;
        end
    end

    assign load_switch_gate_en_o = cur_reg.gate;
    assign cable_power_route_a_o = cur_reg.route_a;
    assign cable_power_route_b_o = cur_reg.route_b;
    assign bus_power_discharge_en_o = cur_reg.dis_bus;
    assign cable_power_discharge_en_o = cur_reg.dis_cable;
    assign cc_path_mode_o = cur_reg.cc_mode;
    assign cc_ovp_en_o = cur_reg.ovp_en;
    assign current_sense_out_en_o = cur_reg.sense_en;
    assign bus_ocp_en_o = cur_reg.ocp_en;
    // Open drain: pull low only, never drive high
    assign fault_out_n_o = 1'b0;
    assign fault_out_n_oe_o = cur_reg.fault;
endmodule : tsp_protect_ctrl

// ---- logic/tsp_pkg.sv ----
// Shared constants for the source-port protection control block
package tsp_pkg;
    // Register pointers on the serial bus
    localparam logic [7:0] REG_CONTROL_WRITE = 8'h00;
    localparam logic [7:0] REG_CONTROL_ACK = 8'h01;
    localparam logic [7:0] REG_FAULT_FLAGS = 8'h02;
    // Control word bit positions
    localparam int BIT_CABLE_DIS = 7;
    localparam int BIT_BUS_DIS = 6;
    localparam int BIT_MODE_HI = 5;
    localparam int BIT_MODE_LO = 4;
    localparam int BIT_ACK3 = 3;
    localparam int BIT_GATE = 2;
    localparam int BIT_ROUTE_B = 1;
    localparam int BIT_ROUTE_A = 0;
    // Power mode codes, high bit first
    localparam logic [1:0] MODE_HIBERNATE = 2'h0;
    localparam logic [1:0] MODE_NORMAL = 2'h1;
    localparam logic [1:0] MODE_LOW_POWER = 2'h2;
    localparam logic [1:0] MODE_UNUSED = 2'h3;
    // Cable power routing codes
    localparam logic [1:0] ROUTE_A = 2'h1;
    localparam logic [1:0] ROUTE_B = 2'h2;
    // CC path condition driven to the analog switches
    localparam logic [1:0] CC_OFF = 2'h0;
    localparam logic [1:0] CC_HIGH_OHMIC = 2'h1;
    localparam logic [1:0] CC_FULL = 2'h2;
    // Recovery word: mode bits are free, all others fixed
    localparam logic [7:0] RECOVERY_MASK = 8'hCF;
    localparam logic [7:0] RECOVERY_VALUE = 8'h08;
    // Target address, upper six bits; lowest bit from the select pin
    localparam logic [5:0] TARGET_ADDR_HI = 6'h1A;
    // Reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] IDLE_BYTE = 8'h00;
    // Synchronised pin indices
    localparam int PIN_EN = 0;
    localparam int PIN_ADDR_SEL = 1;
    localparam int PIN_OVP_CC = 2;
    localparam int PIN_OTP = 3;
    localparam int PIN_OCP_BUS = 4;
    localparam int PIN_OCP_CABLE = 5;
    localparam int PIN_COUNT = 6;
    // Overcurrent hold time before recovery is accepted
    localparam int CLK_FREQ_MHZ = 125;
    localparam int OCP_HOLD_NS = 40000;
    localparam int OCP_HOLD_CYCLES = (OCP_HOLD_NS * CLK_FREQ_MHZ) / 1000;
    localparam int HOLD_W = 16;
    // Serial engine bit counter
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
endpackage : tsp_pkg

// ---- logic/tsp_i2c_target.sv ----
// Serial bus target engine, oversampling the bus pins on the system clock
`timescale 1ns/1ps
module tsp_i2c_target
    import tsp_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic addr_lsb_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic wr_stb_o,
    output logic [7:0] wr_ptr_o,
    output logic [7:0] wr_data_o,
    output logic [7:0] rd_ptr_o,
    input wire logic [7:0] rd_data_i
);
    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_ADDR  = 7'h02,
        ST_ACK_A = 7'h04,
        ST_WBYTE = 7'h08,
        ST_ACK_W = 7'h10,
        ST_RBYTE = 7'h20,
        ST_ACK_R = 7'h40
    } tsp_i2c_state_t;

    typedef struct packed {
        logic [1:0] ff1;
        logic [1:0] ff2;
        logic [1:0] ff3;
        logic scl;
        logic sda;
        tsp_i2c_state_t state;
        logic [3:0] cnt;
        logic [7:0] shift;
        logic rw;
        logic nack;
        logic got_ptr;
        logic [7:0] ptr;
        logic drive;
        logic wr_stb;
        logic [7:0] wr_data;
    } tsp_i2c_t;

    tsp_i2c_t cur_reg;
    tsp_i2c_t cur_next;
    logic scl_new;
    logic sda_new;
    logic scl_rise;
    logic scl_fall;

    // Change accepted once second and third stages agree
    assign scl_new = (cur_reg.ff2[0] == cur_reg.ff3[0]) ? cur_reg.ff3[0] : cur_reg.scl;
    assign sda_new = (cur_reg.ff2[1] == cur_reg.ff3[1]) ? cur_reg.ff3[1] : cur_reg.sda;
    assign scl_rise = !cur_reg.scl && scl_new;
    assign scl_fall = cur_reg.scl && !scl_new;

    always_comb begin
        cur_next = cur_reg;
        cur_next.ff1 = {sda_i, scl_i};
        cur_next.ff2 = cur_reg.ff1;
        cur_next.ff3 = cur_reg.ff2;
        cur_next.scl = scl_new;
        cur_next.sda = sda_new;
        cur_next.wr_stb = 1'b0;
        if (cur_reg.scl && scl_new && cur_reg.sda && !sda_new) begin
            cur_next.state = ST_ADDR;
            cur_next.cnt = 4'h0;
            cur_next.got_ptr = 1'b0;
            cur_next.drive = 1'b0;
        end else if (cur_reg.scl && scl_new && !cur_reg.sda && sda_new) begin
            cur_next.state = ST_IDLE;
            cur_next.drive = 1'b0;
        end else begin
            unique case (cur_reg.state)
                ST_IDLE: begin
                    cur_next.drive = 1'b0;
                end
                ST_ADDR, ST_WBYTE: begin
                    if (scl_rise) begin
                        cur_next.shift = {cur_reg.shift[6:0], sda_new};
                        cur_next.cnt = cur_reg.cnt + 4'h1;
                    end else if (scl_fall && cur_reg.cnt == BITS_PER_BYTE) begin
                        if (cur_reg.state == ST_ADDR) begin
                            // Address decode with strap-selected lowest bit
                            if (cur_reg.shift[7:1] == {TARGET_ADDR_HI, addr_lsb_i}) begin
                                cur_next.drive = 1'b1;
                                cur_next.rw = cur_reg.shift[0];
                                cur_next.state = ST_ACK_A;
                            end else begin
                                cur_next.state = ST_IDLE;
                            end
                        end else begin
                            cur_next.drive = 1'b1;
                            cur_next.state = ST_ACK_W;
                            if (!cur_reg.got_ptr) begin
                                cur_next.ptr = cur_reg.shift;
                                cur_next.got_ptr = 1'b1;
                            end else begin
                                cur_next.wr_stb = 1'b1;
                                cur_next.wr_data = cur_reg.shift;
                            end
                        end
                    end
                end
                ST_ACK_A, ST_ACK_W: begin
                    if (scl_fall) begin
                        cur_next.cnt = 4'h0;
                        if (cur_reg.state == ST_ACK_A && cur_reg.rw) begin
                            cur_next.drive = !rd_data_i[7];
                            cur_next.shift = {rd_data_i[6:0], 1'b0};
                            cur_next.state = ST_RBYTE;
                        end else begin
                            cur_next.drive = 1'b0;
                            cur_next.state = ST_WBYTE;
                        end
                    end
                end
                ST_RBYTE: begin
                    if (scl_rise) begin
                        cur_next.cnt = cur_reg.cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (cur_reg.cnt == BITS_PER_BYTE) begin
                            cur_next.drive = 1'b0;
                            cur_next.state = ST_ACK_R;
                        end else begin
                            cur_next.drive = !cur_reg.shift[7];
                            cur_next.shift = {cur_reg.shift[6:0], 1'b0};
                        end
                    end
                end
                ST_ACK_R: begin
                    if (scl_rise) begin
                        cur_next.nack = sda_new;
                    end else if (scl_fall) begin
                        cur_next.cnt = 4'h0;
                        // Same register again; no pointer increment
                        if (cur_reg.nack) begin
                            cur_next.state = ST_IDLE;
                        end else begin
                            cur_next.drive = !rd_data_i[7];
                            cur_next.shift = {rd_data_i[6:0], 1'b0};
                            cur_next.state = ST_RBYTE;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            cur_reg <= '{ff1: 2'h3, ff2: 2'h3, ff3: 2'h3, scl: 1'b1, sda: 1'b1, state: ST_IDLE,
                         cnt: 4'h0, shift: IDLE_BYTE, rw: 1'b0, nack: 1'b0, got_ptr: 1'b0,
                         ptr: IDLE_BYTE, drive: 1'b0, wr_stb: 1'b0, wr_data: IDLE_BYTE};
        end else begin
            cur_reg <= cur_next;
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe_o = cur_reg.drive;
    assign wr_stb_o = cur_reg.wr_stb;
    assign wr_ptr_o = cur_reg.ptr;
    assign wr_data_o = cur_reg.wr_data;
    assign rd_ptr_o = cur_reg.ptr;
endmodule : tsp_i2c_target

// ---- test/tsp_protect_ctrl_properties.sv ----
// Port-level checks for the protection control block
`timescale 1ns/1ps
module tsp_protect_ctrl_properties
    import tsp_pkg::*;
#(
    parameter int OCP_HOLD = OCP_HOLD_CYCLES,
    parameter logic PART_CODE = 1'b0
)
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic en_i,
    input wire logic otp_i,
    input wire logic ocp_bus_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic load_switch_gate_en_o,
    input wire logic cable_power_route_a_o,
    input wire logic cable_power_route_b_o,
    input wire logic bus_power_discharge_en_o,
    input wire logic cable_power_discharge_en_o,
    input wire logic [1:0] cc_path_mode_o,
    input wire logic cc_ovp_en_o,
    input wire logic current_sense_out_en_o,
    input wire logic bus_ocp_en_o,
    input wire logic fault_out_n_o,
    input wire logic fault_out_n_oe_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);
    sequence all_off;
        !load_switch_gate_en_o && !cable_power_route_a_o && !cable_power_route_b_o && !bus_power_discharge_en_o
            && !cable_power_discharge_en_o && cc_path_mode_o == CC_OFF && !fault_out_n_oe_o && !sda_oe_o;
    endsequence
    sequence trip_seen;
        bus_ocp_en_o && ocp_bus_i;
    endsequence
    sequence tripped;
        !load_switch_gate_en_o && !cable_power_route_a_o && !cable_power_route_b_o && bus_power_discharge_en_o
            && cable_power_discharge_en_o && fault_out_n_oe_o && !bus_ocp_en_o;
    endsequence
    a_off_quiet: assert property (!en_i [*8] |-> all_off) else $error("active while disabled");
    a_start_hibernate: assert property ($rose(en_i) |-> all_off [*8]) else $error("not hibernate");
    a_lowpower_quiet: assert property (cc_path_mode_o == CC_HIGH_OHMIC |-> cc_ovp_en_o
        && !load_switch_gate_en_o && !current_sense_out_en_o && !bus_ocp_en_o) else $error("low power active");
    a_gate_normal: assert property (load_switch_gate_en_o |-> cc_path_mode_o == CC_FULL)
        else $error("gate outside normal");
    a_ocp_normal: assert property (bus_ocp_en_o |-> current_sense_out_en_o)
        else $error("overcurrent armed outside normal");
    a_route_single: assert property (!(cable_power_route_a_o && cable_power_route_b_o))
        else $error("both routes closed");
    a_no_short: assert property (cable_power_discharge_en_o |-> !cable_power_route_a_o && !cable_power_route_b_o)
        else $error("discharge with route closed");
    a_pins_low: assert property (!sda_o && !fault_out_n_o) else $error("open drain level high");
    a_hot_fault: assert property (otp_i [*8] ##1 current_sense_out_en_o |-> fault_out_n_oe_o)
        else $error("no fault when hot");
    a_trip_response: assert property (trip_seen |-> ##[1:8] tripped) else $error("no trip response");
    a_trip_holds: assert property ($rose(bus_power_discharge_en_o && fault_out_n_oe_o && !bus_ocp_en_o)
        |-> (fault_out_n_oe_o && !load_switch_gate_en_o) [*8]) else $error("trip not held");
endmodule : tsp_protect_ctrl_properties

bind tsp_protect_ctrl tsp_protect_ctrl_properties #(.OCP_HOLD(OCP_HOLD), .PART_CODE(PART_CODE)) u_props (
    .clk_sys_i, .rst_i, .en_i, .otp_i, .ocp_bus_i, .sda_o, .sda_oe_o, .load_switch_gate_en_o,
    .cable_power_route_a_o, .cable_power_route_b_o, .bus_power_discharge_en_o, .cable_power_discharge_en_o,
    .cc_path_mode_o, .cc_ovp_en_o, .current_sense_out_en_o, .bus_ocp_en_o, .fault_out_n_o, .fault_out_n_oe_o
);

// ---- test/tsp_host_model.sv ----
// Serial bus host model standing in for the controlling microcontroller
`timescale 1ns/1ps
module tsp_host_model (
    input wire logic clk_sys_i,
    input wire logic sda_oe_i,
    output logic scl_o,
    output wire logic sda_line_o
);
    localparam int QUARTER = 16;
    logic pull_low_reg = 1'b0;
    initial scl_o = 1'b1;
    // Pull-up: released line reads high
    assign sda_line_o = ~(pull_low_reg | sda_oe_i);
    task automatic step(input logic low, input logic scl);
        pull_low_reg <= low;
        scl_o <= scl;
        repeat (QUARTER) @(posedge clk_sys_i);
    endtask : step
    task automatic bit_x(input logic b, output logic r);
        step(~b, 1'b0);
        step(~b, 1'b1);
        r = sda_line_o;
        step(~b, 1'b1);
        step(~b, 1'b0);
    endtask : bit_x
    task automatic start();
        step(1'b0, 1'b0);
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
    endtask : start
    task automatic stop();
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
    endtask : stop
    task automatic byte_x(input logic [7:0] d, output logic [7:0] r, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r[i]);
        end
        bit_x(1'b1, a);
        ack = ~a;
    endtask : byte_x
    task automatic write_reg(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic k1, k2, k3;
        start();
        byte_x({a, 1'b0}, r, k1);
        byte_x(p, r, k2);
        byte_x(d, r, k3);
        stop();
        ok = k1 & k2 & k3;
    endtask : write_reg
    task automatic read_reg(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic k1, k2, k3, k4;
        start();
        byte_x({a, 1'b0}, r, k1);
        byte_x(p, r, k2);
        start();
        byte_x({a, 1'b1}, r, k3);
        // Last byte is refused by the host to end the read
        byte_x(8'hFF, d, k4);
        stop();
        ok = k1 & k2 & k3;
    endtask : read_reg
endmodule : tsp_host_model

// ---- test/tb_top.sv ----
// Self-checking bench for the source-port protection control block
`timescale 1ns/1ps
module tb_top
    import tsp_pkg::*;
;
    // Short hold keeps the run brief, yet longer than one bus write
    localparam int HOLD = 3000;
    localparam logic PART = 1'b1; // Arbitrary value
    localparam int LIMIT = 95000;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic en_i = 1'b1;
    logic addr_sel_i = 1'b0;
    logic ovp_cc_i = 1'b0, otp_i = 1'b0, ocp_bus_i = 1'b0, ocp_cable_i = 1'b0;
    logic scl, sda_oe_o, load_switch_gate_en_o, cable_power_route_a_o, cable_power_route_b_o;
    logic bus_power_discharge_en_o, cable_power_discharge_en_o, cc_ovp_en_o, current_sense_out_en_o;
    logic bus_ocp_en_o, fault_out_n_oe_o, ok;
    logic [1:0] cc_path_mode_o;
    wire logic sda_line;
    logic [6:0] addr = {TARGET_ADDR_HI, 1'b0};
    logic [7:0] v;
    logic [9:0] outs;
    logic [1:0] modes [4] = '{MODE_HIBERNATE, MODE_LOW_POWER, MODE_NORMAL, MODE_UNUSED};
    logic [9:0] mode_outs [4] = '{10'h000, 10'h008, 10'h016, 10'h000};
    int errors = 0;
    int checks_done = 0;
    int cycles = 0;
    assign outs = {load_switch_gate_en_o, cable_power_route_a_o, cable_power_route_b_o, bus_power_discharge_en_o,
        cable_power_discharge_en_o, cc_path_mode_o, current_sense_out_en_o, bus_ocp_en_o, fault_out_n_oe_o};
    tsp_protect_ctrl #(.OCP_HOLD(HOLD), .PART_CODE(PART)) uut (
        .clk_sys_i, .rst_i, .en_i, .addr_sel_i, .scl_i(scl), .sda_i(sda_line), .sda_o(), .sda_oe_o,
        .ovp_cc_i, .otp_i, .ocp_bus_i, .ocp_cable_i, .load_switch_gate_en_o, .cable_power_route_a_o,
        .cable_power_route_b_o, .bus_power_discharge_en_o, .cable_power_discharge_en_o, .cc_path_mode_o,
        .cc_ovp_en_o, .current_sense_out_en_o, .bus_ocp_en_o, .fault_out_n_o(), .fault_out_n_oe_o
    );
    tsp_host_model host (.clk_sys_i, .sda_oe_i(sda_oe_o), .scl_o(scl), .sda_line_o(sda_line));
    initial begin
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    task automatic complete_run();
        if (errors == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run
    always @(posedge clk_sys_i) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            errors = errors + 1;
            complete_run();
        end
    end
    task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask : chk
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask : wait_n
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        host.write_reg(addr, p, d, ok);
        chk("ack", 10'h001, {9'h0, ok});
    endtask : wr
    task automatic rd(input logic [7:0] p, input logic [7:0] e);
        host.read_reg(addr, p, v, ok);
        chk("read", {2'h0, e}, {2'h0, v});
    endtask : rd
    initial begin
        wait_n(10);
        rst_i <= 1'b0;
        wait_n(20);
        chk("outputs", 10'h000, outs);
        rd(REG_CONTROL_ACK, 8'h00);
        rd(REG_FAULT_FLAGS, {PART, 7'h00});
        for (int i = 0; i < 4; i++) begin
            wr(REG_CONTROL_WRITE, {2'h0, modes[i], 4'h0});
            chk("outputs", mode_outs[i], outs);
            rd(REG_CONTROL_ACK, {2'h0, (modes[i] == MODE_UNUSED) ? 2'h0 : modes[i], 4'h0});
        end
        wr(REG_CONTROL_WRITE, 8'h25);
        chk("outputs", 10'h008, outs);
        wr(REG_CONTROL_WRITE, 8'h15);
        chk("outputs", 10'h316, outs);
        wr(REG_CONTROL_WRITE, 8'h16);
        chk("outputs", 10'h296, outs);
        wr(REG_CONTROL_WRITE, 8'h17);
        chk("outputs", 10'h216, outs);
        rd(REG_CONTROL_ACK, 8'h14);
        wr(REG_CONTROL_WRITE, 8'h95);
        chk("outputs", 10'h316, outs);
        wr(REG_CONTROL_WRITE, 8'hD0);
        chk("outputs", 10'h076, outs);
        wr(REG_CONTROL_ACK, 8'hFF);
        rd(REG_CONTROL_ACK, 8'hD0);
        rd(8'h03, 8'h00);
        wr(REG_CONTROL_WRITE, 8'h18);
        rd(REG_CONTROL_ACK, 8'h18);
        en_i <= 1'b0;
        addr_sel_i <= 1'b1;
        wait_n(12);
        chk("outputs", 10'h000, outs);
        en_i <= 1'b1;
        wait_n(20);
        addr = {TARGET_ADDR_HI, 1'b1};
        rd(REG_CONTROL_ACK, 8'h00);
        host.write_reg({TARGET_ADDR_HI, 1'b0}, REG_CONTROL_WRITE, 8'h10, ok);
        chk("foreign address", 10'h000, {outs[9:1], ok});
        wr(REG_CONTROL_WRITE, 8'h10);
        otp_i <= 1'b1;
        wait_n(12);
        chk("fault", 10'h001, {9'h0, fault_out_n_oe_o});
        rd(REG_FAULT_FLAGS, {PART, 7'h08});
        otp_i <= 1'b0;
        ovp_cc_i <= 1'b1;
        wait_n(12);
        chk("fault", 10'h001, {9'h0, fault_out_n_oe_o});
        rd(REG_FAULT_FLAGS, {PART, 7'h10});
        ovp_cc_i <= 1'b0;
        wait_n(12);
        chk("fault", 10'h000, {9'h0, fault_out_n_oe_o});
        wr(REG_CONTROL_WRITE, 8'h00);
        otp_i <= 1'b1;
        ocp_bus_i <= 1'b1;
        wait_n(12);
        chk("outputs", 10'h000, outs);
        otp_i <= 1'b0;
        ocp_bus_i <= 1'b0;
        rd(REG_FAULT_FLAGS, {PART, 7'h00});
        wr(REG_CONTROL_WRITE, 8'h15);
        ocp_bus_i <= 1'b1;
        wait_n(12);
        ocp_bus_i <= 1'b0;
        wait_n(4);
        chk("outputs", 10'h065, outs);
        // Recovery word before the hold has run out must not release
        wr(REG_CONTROL_WRITE, 8'h18);
        chk("held", 10'h001, {8'h0, load_switch_gate_en_o, fault_out_n_oe_o});
        rd(REG_FAULT_FLAGS, {PART, 7'h22});
        wait_n(HOLD);
        wr(REG_CONTROL_WRITE, 8'h15);
        chk("held", 10'h001, {8'h0, load_switch_gate_en_o, fault_out_n_oe_o});
        wr(REG_CONTROL_WRITE, 8'h18);
        chk("outputs", 10'h016, outs);
        wr(REG_CONTROL_WRITE, 8'h15);
        chk("outputs", 10'h316, outs);
        ocp_cable_i <= 1'b1;
        wait_n(12);
        ocp_cable_i <= 1'b0;
        chk("outputs", 10'h065, outs);
        rd(REG_FAULT_FLAGS, {PART, 7'h01});
        complete_run();
    end
endmodule : tb_top
